// ### pbc_pkg.sv
// constants shared by the pwm blanking, chop and capture block
// ----------------------------------------------------------------
// Notes on behaviour
// R1: low-output-high enable masks current-limit and fault while low side high
// R2: low-output-low enable masks current-limit and fault while low side low
// R3: nine-bit blanking delay in bits 11..3, each count 8.32 ns; the timer steps 12 ns (three 4 ns clocks) per count
// R4: delay register bits 15..12 and 2..0 always read zero
// R5: state-blank source 0 none, 1..5 generator high output, 6..9 reserved
// R6: selected blank signal masks inputs only with its high/low enables
// R7: chop source 0 internal chop clock, 1..5 generator high output
// R8: chop source signal alternately enables and disables chopped outputs
// R9: high-side chop enable chops the high-side output
// R10: low-side chop enable chops the low-side output
// R11: fine period off bit shuts down fine period logic
// R12: fine duty off bit shuts down fine duty logic
// R13: current-limit leading edge stores time base into bits 15..3
// R14: capture exists only for the primary high-side output
// R15: capture only after leading-edge blanking of current-limit completes
// R16: captured value resolution is 8.32 ns steps; the time base here counts one 4 ns clock per step
// R17: software uses capture only with external period reset cleared
// R18: enabled output edge loads delay count and masks inputs until expiry
// R19: all writable fields reset to zero
// ----------------------------------------------------------------
package pbc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_EDGE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_AUX = 8'h08;
    localparam logic [7:0] ADDR_CAPTURE = 8'h0c;
    // reset values
    localparam logic [15:0] RST_EDGE_CTRL = 16'h0000;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_AUX = 16'h0000;
    localparam logic [15:0] RST_CAPTURE = 16'h0000;
    // writable bit masks
    localparam logic [15:0] MASK_EDGE_CTRL = 16'hfc3f;
    localparam logic [15:0] MASK_DELAY = 16'h0ff8;
    localparam logic [15:0] MASK_AUX = 16'hcf3f;
    // edge_blank_control fields
    localparam int EB_TRIG_HR = 15;
    localparam int EB_TRIG_HF = 14;
    localparam int EB_TRIG_LR = 13;
    localparam int EB_TRIG_LF = 12;
    localparam int EB_FLT_LEB = 11;
    localparam int EB_CL_LEB = 10;
    localparam int EB_SEL_HIGH = 5;
    localparam int EB_SEL_LOW = 4;
    localparam int EB_HIGH_OUT_HIGH = 3;
    localparam int EB_HIGH_OUT_LOW = 2;
    localparam int EB_LOW_OUT_HIGH = 1;
    localparam int EB_LOW_OUT_LOW = 0;
    // blanking_delay field
    localparam int DLY_LSB = 3;
    localparam int DLY_W = 9;
    // aux_blank_chop_control fields
    localparam int AUX_FINE_PERIOD_OFF = 15;
    localparam int AUX_FINE_DUTY_OFF = 14;
    localparam int AUX_BLANK_SRC_LSB = 8;
    localparam int AUX_CHOP_SRC_LSB = 2;
    localparam int SRC_W = 4;
    localparam int AUX_CHOP_HIGH = 1;
    localparam int AUX_CHOP_LOW = 0;
    // time base capture field
    localparam int CAP_LSB = 3;
    localparam int CAP_W = 13;
    localparam int NUM_GEN = 5;
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_LAST = 4'h5;
    // timing: one delay count of 8.32 ns rounds up to three clocks of 4 ns, so 12 ns
    localparam int BLANK_STEP_PS = 8320;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BLANK_STEP_CYC =
        (BLANK_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ### pbc_blank_timer.sv
// leading-edge blanking down-counter with a three-clock (12 ns) step prescaler
`timescale 1ns/1ps
`default_nettype none
module pbc_blank_timer (
    input wire logic clk, // 250 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable
    input wire logic load, // output edge seen
    input wire logic [8:0] count, // delay in steps
    output logic active // blanking window open
);
    localparam logic [1:0] STEP_LAST =
        2'(pbc_pkg::BLANK_STEP_CYC - 1);
    logic [8:0] remain;
    logic [1:0] pre;
    wire step_done = (pre == STEP_LAST);

    // a new edge restarts the window even if one is open
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= 9'h000;
            pre <= 2'h0;
        end else if (ce) begin
            if (load) begin // R18
                remain <= count;
                pre <= 2'h0;
            end else if (remain != 9'h000) begin
                pre <= step_done ? 2'h0 : pre + 2'h1;
                if (step_done)
                    remain <= remain - 9'h001; // R3
            end
        end
    end
    assign active = (remain != 9'h000);

    load_opens_a: assert property (@(posedge clk) disable iff (rst) // R18
        ce && load && count != 9'h000 |=> active)
        else $error("blanking window did not open");
endmodule
`default_nettype wire

// ### pbc_blank_chop.sv
// pwm generator blanking, chopping and time base capture
`timescale 1ns/1ps
`default_nettype none
module pbc_blank_chop (
    input wire logic clk, // 250 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable, freezes all state
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic high_in, // this generator high-side output
    input wire logic low_in, // this generator low-side output
    input wire logic [4:0] gen_high, // high-side outputs of all generators
    input wire logic chop_clk, // internal chop clock generator
    input wire logic cur_limit, // current-limit input, active high
    input wire logic fault, // fault input, active high
    input wire logic [12:0] time_base, // primary time base
    output logic high_out, // chopped high-side output
    output logic low_out, // chopped low-side output
    output logic cur_limit_out, // blanked current-limit
    output logic fault_out, // blanked fault
    output logic fine_period_off, // fine period logic shut down
    output logic fine_duty_off // fine duty logic shut down
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] edge_blank_control;
    logic [15:0] blanking_delay;
    logic [15:0] aux_blank_chop_control;
    logic [15:0] time_base_capture;
    logic high_d;
    logic low_d;
    logic cl_pre_d;

    // picks one generator high output; codes past five give no signal
    function automatic logic [1:0] src_pick(input logic [3:0] code,
                                            input logic [4:0] highs);
        logic [1:0] r;
        r = 2'b00;
        if (code != pbc_pkg::SRC_NONE && code <= pbc_pkg::SRC_LAST)
            r = {1'b1, highs[3'(code - 4'h1)]};
        return r;
    endfunction

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_edge = (paddr == pbc_pkg::ADDR_EDGE_CTRL);
    wire hit_delay = (paddr == pbc_pkg::ADDR_DELAY);
    wire hit_aux = (paddr == pbc_pkg::ADDR_AUX);
    wire hit_cap = (paddr == pbc_pkg::ADDR_CAPTURE);
    wire mapped = hit_edge || hit_delay || hit_aux || hit_cap;
    wire wr = access && pwrite && ce;
    wire [15:0] wdata = pwdata[15:0];
    // unmapped addresses and writes to the capture register fail
    wire bad = !mapped || (pwrite && hit_cap);
    wire [15:0] rd_mux =
        hit_edge ? edge_blank_control :
        hit_delay ? blanking_delay : // R4
        hit_aux ? aux_blank_chop_control :
        hit_cap ? time_base_capture : 16'h0000;

    // zero wait states keeps the slave simple; ce low stalls the bus
    assign pready = ce;
    assign pslverr = access && bad;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (ce && setup)
            prdata <= {16'h0000, rd_mux};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edge_blank_control <= pbc_pkg::RST_EDGE_CTRL; // R19
            blanking_delay <= pbc_pkg::RST_DELAY;
            aux_blank_chop_control <= pbc_pkg::RST_AUX;
        end else if (wr) begin
            if (hit_edge)
                edge_blank_control <= wdata & pbc_pkg::MASK_EDGE_CTRL;
            if (hit_delay)
                blanking_delay <= wdata & pbc_pkg::MASK_DELAY; // R4
            if (hit_aux)
                aux_blank_chop_control <= wdata & pbc_pkg::MASK_AUX;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire [8:0] blank_delay_count =
        blanking_delay[pbc_pkg::DLY_LSB +: pbc_pkg::DLY_W]; // R3
    wire [3:0] state_blank_source =
        aux_blank_chop_control[pbc_pkg::AUX_BLANK_SRC_LSB +: pbc_pkg::SRC_W];
    wire [3:0] chop_source =
        aux_blank_chop_control[pbc_pkg::AUX_CHOP_SRC_LSB +: pbc_pkg::SRC_W];
    wire chop_high_en = aux_blank_chop_control[pbc_pkg::AUX_CHOP_HIGH];
    wire chop_low_en = aux_blank_chop_control[pbc_pkg::AUX_CHOP_LOW];
    wire blank_low_out_high_en =
        edge_blank_control[pbc_pkg::EB_LOW_OUT_HIGH];
    wire blank_low_out_low_en = edge_blank_control[pbc_pkg::EB_LOW_OUT_LOW];
    wire blank_high_out_high_en =
        edge_blank_control[pbc_pkg::EB_HIGH_OUT_HIGH];
    wire blank_high_out_low_en =
        edge_blank_control[pbc_pkg::EB_HIGH_OUT_LOW];
    wire blank_sel_high_en = edge_blank_control[pbc_pkg::EB_SEL_HIGH];
    wire blank_sel_low_en = edge_blank_control[pbc_pkg::EB_SEL_LOW];
    wire cl_leb_en = edge_blank_control[pbc_pkg::EB_CL_LEB];
    wire flt_leb_en = edge_blank_control[pbc_pkg::EB_FLT_LEB];

    // ------------------------------------------------------------
    // state blanking
    // ------------------------------------------------------------
    wire [1:0] blank_pick = src_pick(state_blank_source, gen_high); // R5
    wire blank_sig_ok = blank_pick[1];
    wire blank_sig = blank_pick[0];
    wire sel_blank = blank_sig_ok && // R6
        ((blank_sel_high_en && blank_sig) ||
         (blank_sel_low_en && !blank_sig));
    wire low_blank = (blank_low_out_high_en && low_in) || // R1
        (blank_low_out_low_en && !low_in); // R2
    wire high_blank = (blank_high_out_high_en && high_in) ||
        (blank_high_out_low_en && !high_in);
    wire state_blank = sel_blank || low_blank || high_blank;

    // ------------------------------------------------------------
    // leading-edge blanking
    // ------------------------------------------------------------
    wire edge_trig =
        (edge_blank_control[pbc_pkg::EB_TRIG_HR] && high_in && !high_d) ||
        (edge_blank_control[pbc_pkg::EB_TRIG_HF] && !high_in && high_d) ||
        (edge_blank_control[pbc_pkg::EB_TRIG_LR] && low_in && !low_d) ||
        (edge_blank_control[pbc_pkg::EB_TRIG_LF] && !low_in && low_d);
    logic leb_active;

    pbc_blank_timer u_pbc_blank_timer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(edge_trig), // R18
        .count(blank_delay_count),
        .active(leb_active)
    );

    // leb result of current-limit, ahead of state blanking
    wire cl_post_leb = cur_limit && !(cl_leb_en && leb_active); // R15
    wire next_cur_limit_out = cl_post_leb && !state_blank;
    wire next_fault_out = fault && !(flt_leb_en && leb_active) &&
        !state_blank;
    // capture belongs to the primary time base, driven from the blanked current-limit rise
    wire cl_rise = cl_post_leb && !cl_pre_d; // R14

    // ------------------------------------------------------------
    // chopping
    // ------------------------------------------------------------
    wire [1:0] chop_pick = src_pick(chop_source, gen_high); // R7
    // reserved codes leave the chopped outputs off, the safe state
    wire chop_sig = (chop_source == pbc_pkg::SRC_NONE) ? chop_clk :
        chop_pick[1] && chop_pick[0];
    wire next_high_out = high_in && (!chop_high_en || chop_sig); // R9 R8
    wire next_low_out = low_in && (!chop_low_en || chop_sig); // R10 R8

    // ------------------------------------------------------------
    // output and capture flops
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            high_d <= 1'b0;
            low_d <= 1'b0;
            cl_pre_d <= 1'b0;
            high_out <= 1'b0;
            low_out <= 1'b0;
            cur_limit_out <= 1'b0;
            fault_out <= 1'b0;
        end else if (ce) begin
            high_d <= high_in;
            low_d <= low_in;
            cl_pre_d <= cl_post_leb;
            high_out <= next_high_out;
            low_out <= next_low_out;
            cur_limit_out <= next_cur_limit_out;
            fault_out <= next_fault_out;
        end
    end

    // resolution is that of the time base, one 4 ns clock per count
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            time_base_capture <= pbc_pkg::RST_CAPTURE;
        else if (ce && cl_rise)
            time_base_capture <= {time_base, 3'b000}; // R13 R16
    end

    // power-down straps follow the register directly
    assign fine_period_off =
        aux_blank_chop_control[pbc_pkg::AUX_FINE_PERIOD_OFF]; // R11
    assign fine_duty_off =
        aux_blank_chop_control[pbc_pkg::AUX_FINE_DUTY_OFF]; // R12

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    low_high_mask_a: assert property ( // R1
        ce && blank_low_out_high_en && low_in |=> !cur_limit_out && !fault_out)
        else $error("inputs not masked while low side high");
    low_low_mask_a: assert property ( // R2
        ce && blank_low_out_low_en && !low_in |=> !cur_limit_out && !fault_out)
        else $error("inputs not masked while low side low");
    delay_bits_a: assert property ( // R4
        ce && setup && hit_delay |=>
        prdata[15:12] == 4'h0 && prdata[2:0] == 3'h0)
        else $error("unimplemented delay bits read back set");
    reserved_src_a: assert property ( // R5
        ce && state_blank_source > pbc_pkg::SRC_LAST && !low_blank &&
        !high_blank && cur_limit && !(cl_leb_en && leb_active)
        |=> cur_limit_out)
        else $error("reserved blank source masked input");
    sel_mask_a: assert property ( // R6
        ce && blank_sig_ok && blank_sel_high_en && blank_sig
        |=> !cur_limit_out)
        else $error("selected blank signal did not mask");
    leb_mask_a: assert property ( // R18
        ce && edge_trig && blank_delay_count != 9'h000 && cl_leb_en
        ##1 ce |=> !cur_limit_out)
        else $error("leading edge window did not mask");
    chop_high_a: assert property ( // R9
        ce && chop_high_en && !chop_sig |=> !high_out)
        else $error("high side not chopped");
    chop_low_a: assert property ( // R10
        ce && chop_low_en && !chop_sig |=> !low_out)
        else $error("low side not chopped");
    capture_a: assert property ( // R13
        ce && cl_rise |=> time_base_capture[15:3] == $past(time_base))
        else $error("time base not captured");
    fine_off_a: assert property ( // R11
        wr && hit_aux |=>
        fine_period_off == $past(wdata[pbc_pkg::AUX_FINE_PERIOD_OFF]))
        else $error("fine period control not taken");
    fine_duty_a: assert property ( // R12
        wr && hit_aux |=>
        fine_duty_off == $past(wdata[pbc_pkg::AUX_FINE_DUTY_OFF]))
        else $error("fine duty control not taken");
    // a stalled enable must not let outputs or registers drift
    ce_hold_a: assert property (
        !ce |=> $stable(cur_limit_out) && $stable(edge_blank_control))
        else $error("state moved while clock enable low");

    cap_cov: cover property (ce && cl_rise);
    leb_cov: cover property (ce && edge_trig && cl_leb_en && cur_limit);
    chop_cov: cover property (ce && chop_high_en && chop_source != 4'h0);
    err_cov: cover property (pslverr);
    hold_cov: cover property (!ce);
endmodule
`default_nettype wire

// ### pbc_power_stage.sv
// power stage model: chop clock generator and time base that counts unless frozen
`timescale 1ns/1ps
`default_nettype none
module pbc_power_stage (
    input wire logic clk, // pwm clock
    input wire logic rst, // async reset, active high
    input wire logic chop_run, // let the chop clock toggle
    input wire logic freeze, // hold the time base still
    output logic chop_clk, // chop clock, stands still when idle
    output logic [12:0] time_base // primary time base
);
    // the time base is restarted by rst and wraps to zero after 8192 counts, and is otherwise only held
    // by freeze, so a captured value names one point within its 8192-count cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chop_clk <= 1'b0;
            time_base <= 13'h0000;
        end else begin
            if (chop_run) begin
                chop_clk <= ~chop_clk;
            end
            if (!freeze) begin
                time_base <= time_base + 13'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ### pbc_blank_chop_tb.sv
// self-checking bench for the pwm blanking, chop and capture block
`timescale 1ns/1ps
`default_nettype none
module pbc_blank_chop_tb;
    logic clk, rst, ce, psel, penable, pwrite, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, high_in, low_in, chop_clk, cur_limit, fault;
    logic [4:0] gen_high;
    logic [12:0] time_base;
    logic high_out, low_out, cur_limit_out, fault_out;
    logic fine_period_off, fine_duty_off, chop_run, freeze;
    logic [15:0] q, q0;
    int fails, comparisons, cycles;

    pbc_blank_chop u_pbc_blank_chop (.clk(clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_in(high_in), .low_in(low_in),
        .gen_high(gen_high), .chop_clk(chop_clk), .cur_limit(cur_limit),
        .fault(fault), .time_base(time_base), .high_out(high_out),
        .low_out(low_out), .cur_limit_out(cur_limit_out),
        .fault_out(fault_out), .fine_period_off(fine_period_off),
        .fine_duty_off(fine_duty_off));
    pbc_power_stage u_pbc_power_stage (.clk(clk), .rst(rst),
        .chop_run(chop_run), .freeze(freeze), .chop_clk(chop_clk),
        .time_base(time_base));

    // ----------------------------------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input string name, input logic [15:0] exp,
             input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // holds the request until pready is seen high at a rising edge, giving up after 64 edges
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n == 64) begin
            fails++;
        end
        q = prdata[15:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input string name, input logic [7:0] a,
                input logic [15:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(name, exp, q);
        chk({name, "_err"}, 16'h0000, {15'h0, e});
    endtask

    task blank(input logic [15:0] aux, input logic [4:0] gh,
               input logic li, input logic exp);
        apb(1'b1, pbc_pkg::ADDR_AUX, aux);
        @(posedge clk);
        gen_high <= gh;
        low_in <= li;
        tick(3);
        chk("cur_limit_out", {15'h0, exp}, {15'h0, cur_limit_out});
        chk("fault_out", {15'h0, exp}, {15'h0, fault_out});
    endtask

    task chop(input logic [15:0] aux, input logic [4:0] gh);
        logic c, ch;
        logic [3:0] s;
        s = aux[5:2];
        apb(1'b1, pbc_pkg::ADDR_AUX, aux);
        @(posedge clk);
        gen_high <= gh;
        tick(3);
        repeat (6) begin
            c = chop_clk;
            tick(1);
            ch = (s == 4'h0) ? c : ((s <= 4'h5) ? gh[s - 4'h1] : 1'b0);
            chk("high_out", {15'h0, !aux[1] | ch}, {15'h0, high_out});
            chk("low_out", {15'h0, !aux[0] | ch}, {15'h0, low_out});
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        rd_chk("edge_ctrl", pbc_pkg::ADDR_EDGE_CTRL, 16'h0000);
        rd_chk("delay", pbc_pkg::ADDR_DELAY, 16'h0000);
        rd_chk("aux", pbc_pkg::ADDR_AUX, 16'h0000);
        rd_chk("capture", pbc_pkg::ADDR_CAPTURE, 16'h0000);
        apb(1'b0, 8'h10, 16'h0000);
        chk("unmapped_err", 16'h0001, {15'h0, e});
        chk("unmapped_rd", 16'h0000, q);
        apb(1'b1, pbc_pkg::ADDR_DELAY, 16'hffff);
        rd_chk("delay_bits", pbc_pkg::ADDR_DELAY, 16'h0ff8);
        apb(1'b1, pbc_pkg::ADDR_AUX, 16'hffff);
        rd_chk("aux_bits", pbc_pkg::ADDR_AUX, 16'hcf3f);
        chk("fine_off", 16'h0003,
            {14'h0, fine_period_off, fine_duty_off});
        apb(1'b1, pbc_pkg::ADDR_AUX, 16'h4000);
        tick(1);
        chk("fine_off", 16'h0001,
            {14'h0, fine_period_off, fine_duty_off});
        apb(1'b1, pbc_pkg::ADDR_CAPTURE, 16'hfff8);
        chk("capture_wr_err", 16'h0001, {15'h0, e});
        rd_chk("capture_ro", pbc_pkg::ADDR_CAPTURE, 16'h0000);
    endtask

    task t_state;
        @(posedge clk);
        cur_limit <= 1'b1;
        fault <= 1'b1;
        apb(1'b1, pbc_pkg::ADDR_EDGE_CTRL, 16'h0002);
        blank(16'h0000, 5'h00, 1'b1, 1'b0);
        blank(16'h0000, 5'h00, 1'b0, 1'b1);
        apb(1'b1, pbc_pkg::ADDR_EDGE_CTRL, 16'h0001);
        blank(16'h0000, 5'h00, 1'b0, 1'b0);
        blank(16'h0000, 5'h00, 1'b1, 1'b1);
        apb(1'b1, pbc_pkg::ADDR_EDGE_CTRL, 16'h0020);
        for (int k = 1; k <= 5; k++) begin
            blank(16'(k << 8), 5'(1 << (k - 1)), 1'b0, 1'b0);
            blank(16'(k << 8), ~5'(1 << (k - 1)), 1'b0, 1'b1);
        end
        blank(16'h0000, 5'h1f, 1'b0, 1'b1);
        blank(16'h0600, 5'h1f, 1'b0, 1'b1);
        apb(1'b1, pbc_pkg::ADDR_EDGE_CTRL, 16'h0010);
        blank(16'h0100, 5'h00, 1'b0, 1'b0);
        blank(16'h0100, 5'h01, 1'b0, 1'b1);
        apb(1'b1, pbc_pkg::ADDR_EDGE_CTRL, 16'h0000);
    endtask

    task t_chop;
        @(posedge clk);
        high_in <= 1'b1;
        low_in <= 1'b1;
        chop_run <= 1'b1;
        chop(16'h0002, 5'h00);
        chop(16'h0001, 5'h00);
        chop(16'h0000, 5'h00);
        for (int k = 1; k <= 5; k++) begin
            chop(16'(k << 2) | 16'h0003, 5'(1 << (k - 1)));
            chop(16'(k << 2) | 16'h0003, ~5'(1 << (k - 1)));
        end
        chop(16'h001b, 5'h1f);
        @(posedge clk);
        chop_run <= 1'b0;
        high_in <= 1'b0;
        low_in <= 1'b0;
    endtask

    task t_leb;
        apb(1'b1, pbc_pkg::ADDR_AUX, 16'h0000);
        apb(1'b1, pbc_pkg::ADDR_DELAY, 16'h0020);
        apb(1'b1, pbc_pkg::ADDR_EDGE_CTRL, 16'h8c00);
        tick(4);
        @(posedge clk);
        high_in <= 1'b1;
        tick(3);
        chk("cur_limit_out", 16'h0000, {15'h0, cur_limit_out});
        chk("fault_out", 16'h0000, {15'h0, fault_out});
        tick(11);
        chk("cur_limit_out", 16'h0000, {15'h0, cur_limit_out});
        tick(1);
        chk("cur_limit_out", 16'h0001, {15'h0, cur_limit_out});
        @(posedge clk);
        high_in <= 1'b0;
        tick(3);
        chk("cur_limit_out", 16'h0001, {15'h0, cur_limit_out});
        @(posedge clk);
        cur_limit <= 1'b0;
        apb(1'b0, pbc_pkg::ADDR_CAPTURE, 16'h0000);
        q0 = q;
        @(posedge clk);
        high_in <= 1'b1;
        tick(3);
        @(posedge clk);
        cur_limit <= 1'b1;
        tick(2);
        @(posedge clk);
        cur_limit <= 1'b0;
        tick(20);
        rd_chk("capture_blanked", pbc_pkg::ADDR_CAPTURE, q0);
        @(posedge clk);
        freeze <= 1'b1;
        tick(2);
        @(posedge clk);
        cur_limit <= 1'b1;
        tick(4);
        rd_chk("capture", pbc_pkg::ADDR_CAPTURE,
               {time_base, 3'b000});
        @(posedge clk);
        freeze <= 1'b0;
    endtask

    // clock enable stall, then a reset in mid-run over written registers
    task t_hold;
        @(posedge clk);
        ce <= 1'b0;
        cur_limit <= 1'b0;
        tick(3);
        chk("pready", 16'h0000, {15'h0, pready});
        chk("cur_limit_out", 16'h0001, {15'h0, cur_limit_out});
        @(posedge clk);
        ce <= 1'b1;
        tick(3);
        chk("cur_limit_out", 16'h0000, {15'h0, cur_limit_out});
        @(posedge clk);
        rst <= 1'b1;
        tick(2);
        @(posedge clk);
        rst <= 1'b0;
        rd_chk("edge_ctrl", pbc_pkg::ADDR_EDGE_CTRL, 16'h0000);
        rd_chk("delay", pbc_pkg::ADDR_DELAY, 16'h0000);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {high_in, low_in, gen_high, cur_limit, fault} = '0;
        {chop_run, freeze, fails, comparisons, cycles} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_state();
        t_chop();
        t_leb();
        t_hold();
        report_and_stop();
    end
endmodule
`default_nettype wire
